// ---- include/i2cs_map.vh ----
// Behaviour
// - address hold stretches, interrupts after 8th edge
// - start sets status; interrupt only if enabled
// - buffer read returns address, clears full flag
// - setting clock release stops holding clock low
// - read request stretches clock and interrupts
// - buffer load after ack sets full flag
// - master ack copied into ack received bit
// - stretch and interrupt repeat after every byte the master acks
// - master not-ack releases bus entirely
`ifndef I2CS_MAP_VH
`define I2CS_MAP_VH

// register byte offsets on the wishbone bus
`define I2CS_OFS_CTRL 8'h00
`define I2CS_OFS_STATUS 8'h04
`define I2CS_OFS_BUF 8'h08
`define I2CS_OFS_OWN 8'h0c
`define I2CS_OFS_IRQ_STAT 8'h10
`define I2CS_OFS_IRQ_MASK 8'h14

// port_control_three / port_control_two bits, gathered in ctrl
`define I2CS_CTRL_HOLD 0
`define I2CS_CTRL_START_IE 1
`define I2CS_CTRL_ACK_SEL 2
`define I2CS_CTRL_RELEASE 3

// port_status_reg bits (read only)
`define I2CS_ST_START 0
`define I2CS_ST_RW 1
`define I2CS_ST_DNA 2
`define I2CS_ST_FULL 3
`define I2CS_ST_ACK_TIME 4
`define I2CS_ST_ACKRX 5
`define I2CS_ST_STOP 6

// sticky interrupt status bits, write one to clear
`define I2CS_IRQ_PORT 0
`define I2CS_IRQ_NACK 1
`define I2CS_IRQ_STOP 2
`define I2CS_IRQ_W 3

// reset values and the last bit index of a byte
`define I2CS_RST_CTRL 4'h8
`define I2CS_RST_OWN 7'h2a
`define I2CS_RST_MASK 3'h0
`define I2CS_LAST_BIT 3'h7

`endif

// ---- hw/i2cs_sync.v ----
`default_nettype none

module i2cs_sync #(
    parameter WIDTH = 2
) (
    // clock and reset
    input wire ref_clk_i,
    input wire rst_n_i,
    // asynchronous levels in, synchronised levels out
    input wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);

    reg [WIDTH-1:0] meta_q; // first stage, read only by the second
    reg [WIDTH-1:0] sync_q; // second stage, safe to use

    // two flip-flops; idle bus lines are high, so reset to ones
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= {WIDTH{1'b1}};
            sync_q <= {WIDTH{1'b1}};
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule // i2cs_sync

`default_nettype wire

// ---- hw/i2cs_top.v ----
`include "i2cs_map.vh"
`default_nettype none

module i2cs_top (
    // clock and reset
    input wire ref_clk_i,
    input wire resetn_i,
    // wishbone classic slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire wb_ack_o,
    // i2c clock line, open drain
    input wire scl_i,
    output wire scl_o,
    output wire scl_oe_o,
    // i2c data line, open drain
    input wire sda_i,
    output wire sda_o,
    output wire sda_oe_o,
    // interrupt
    output wire irq_o
);

    // one-hot engine states
    localparam [5:0] ST_IDLE = 6'h01; // bus free or not selected yet
    localparam [5:0] ST_ADDR = 6'h02; // clocking in address byte
    localparam [5:0] ST_AACK = 6'h04; // address acknowledge phase
    localparam [5:0] ST_TX = 6'h08; // shifting a byte to the master
    localparam [5:0] ST_DACK = 6'h10; // waiting for master ack
    localparam [5:0] ST_WAIT = 6'h20; // not ours, refused, a write, or not-acked: wait for stop

    // control reset word; each bit's reset value is picked out of it
    localparam [3:0] RST_CTRL = `I2CS_RST_CTRL;

    // reset release
    reg rst_meta_q;
    reg rst_n_q;

    // bus slave
    reg ack_q;
    reg [31:0] dat_q;
    reg [31:0] rd_data_d;

    // control bits
    reg addr_hold_enable_q;
    reg start_ie_q;
    reg ack_value_select_q;
    reg clock_release_q;
    reg [6:0] own_addr_q;

    // status bits
    reg start_seen_q;
    reg stop_seen_q;
    reg rw_q;
    reg data_not_addr_q;
    reg buffer_full_q;
    reg ack_time_flag_q;
    reg ack_received_q;
    reg [`I2CS_IRQ_W-1:0] irq_stat_q;
    reg [`I2CS_IRQ_W-1:0] irq_mask_q;

    // engine
    reg [5:0] state_q;
    reg [2:0] bit_cnt_q;
    reg [7:0] shift_q; // incoming address bits
    reg [7:0] tx_shift_q; // outgoing data, msb first
    reg [7:0] shift_buffer_q; // software view of the byte
    reg hold_q; // address hold was on when matched
    reg bit_seen_q; // a clock rise came since the last counted fall
    reg scl_prev_q;
    reg sda_prev_q;

    // pin and irq outputs
    reg scl_oe_q;
    reg sda_oe_q;
    reg line_o_q; // open drain only ever drives low
    reg irq_q;

    wire [1:0] pins_s;
    wire scl_s;
    wire sda_s;
    wire scl_rise;
    wire scl_fall;
    wire start_det;
    wire stop_det;
    wire bus_req;
    wire wr_stb;
    wire rd_stb;
    wire addr_match;

    // asynchronous assert, two-flop release of reset
    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // both bus lines come from outside, synchronise before use
    i2cs_sync #(
        .WIDTH(2)
    ) i2cs_sync_inst (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_q),
        .async_i({scl_i, sda_i}),
        .sync_o(pins_s)
    );

    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    // edges and bus conditions on the synchronised lines
    assign scl_rise = scl_s & ~scl_prev_q;
    assign scl_fall = ~scl_s & scl_prev_q;
    assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    assign stop_det = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

    // a request is served once; ack_q blocks the repeat cycle
    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr_stb = bus_req & wb_we_i & wb_sel_i[0];
    assign rd_stb = bus_req & ~wb_we_i;

    // seven address bits against own address
    assign addr_match = (shift_q[7:1] == own_addr_q);

    // read data mux; unmapped offsets read as zero
    always @* begin
        rd_data_d = 32'h0000_0000;
        case (wb_adr_i)
            `I2CS_OFS_CTRL: begin
                rd_data_d[`I2CS_CTRL_HOLD] = addr_hold_enable_q;
                rd_data_d[`I2CS_CTRL_START_IE] = start_ie_q;
                rd_data_d[`I2CS_CTRL_ACK_SEL] = ack_value_select_q;
                rd_data_d[`I2CS_CTRL_RELEASE] = clock_release_q;
            end
            `I2CS_OFS_STATUS: begin
                rd_data_d[`I2CS_ST_START] = start_seen_q;
                rd_data_d[`I2CS_ST_RW] = rw_q;
                rd_data_d[`I2CS_ST_DNA] = data_not_addr_q;
                rd_data_d[`I2CS_ST_FULL] = buffer_full_q;
                rd_data_d[`I2CS_ST_ACK_TIME] = ack_time_flag_q;
                rd_data_d[`I2CS_ST_ACKRX] = ack_received_q;
                rd_data_d[`I2CS_ST_STOP] = stop_seen_q;
            end
            `I2CS_OFS_BUF: rd_data_d[7:0] = shift_buffer_q;
            `I2CS_OFS_OWN: rd_data_d[6:0] = own_addr_q;
            `I2CS_OFS_IRQ_STAT: rd_data_d[`I2CS_IRQ_W-1:0] = irq_stat_q;
            `I2CS_OFS_IRQ_MASK: rd_data_d[`I2CS_IRQ_W-1:0] = irq_mask_q;
            default: rd_data_d = 32'h0000_0000;
        endcase
    end

    // registers and engine share one process: software effects come
    // first and hardware events later, so a same-cycle event wins
    always @(posedge ref_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
            addr_hold_enable_q <= RST_CTRL[`I2CS_CTRL_HOLD];
            start_ie_q <= RST_CTRL[`I2CS_CTRL_START_IE];
            ack_value_select_q <= RST_CTRL[`I2CS_CTRL_ACK_SEL];
            clock_release_q <= RST_CTRL[`I2CS_CTRL_RELEASE];
            own_addr_q <= `I2CS_RST_OWN;
            start_seen_q <= 1'b0;
            stop_seen_q <= 1'b0;
            rw_q <= 1'b0;
            data_not_addr_q <= 1'b0;
            buffer_full_q <= 1'b0;
            ack_time_flag_q <= 1'b0;
            ack_received_q <= 1'b0;
            irq_stat_q <= {`I2CS_IRQ_W{1'b0}};
            irq_mask_q <= `I2CS_RST_MASK;
            state_q <= ST_IDLE;
            bit_cnt_q <= 3'h0;
            shift_q <= 8'h00;
            tx_shift_q <= 8'hff;
            shift_buffer_q <= 8'h00;
            hold_q <= 1'b0;
            bit_seen_q <= 1'b0;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            line_o_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            // wishbone answer one cycle after the strobe, for one cycle
            ack_q <= bus_req;
            dat_q <= rd_data_d;
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
            line_o_q <= 1'b0;

            // software writes
            if (wr_stb) begin
                case (wb_adr_i)
                    `I2CS_OFS_CTRL: begin
                        addr_hold_enable_q <= wb_dat_i[`I2CS_CTRL_HOLD];
                        start_ie_q <= wb_dat_i[`I2CS_CTRL_START_IE];
                        ack_value_select_q <= wb_dat_i[`I2CS_CTRL_ACK_SEL];
                        clock_release_q <= wb_dat_i[`I2CS_CTRL_RELEASE];
                    end
                    `I2CS_OFS_BUF: begin
                        // loads only count once the ack phase is over
                        if (state_q == ST_TX && !ack_time_flag_q) begin
                            shift_buffer_q <= wb_dat_i[7:0];
                            tx_shift_q <= wb_dat_i[7:0];
                            buffer_full_q <= 1'b1;
                        end
                    end
                    `I2CS_OFS_OWN: own_addr_q <= wb_dat_i[6:0];
                    `I2CS_OFS_IRQ_STAT: begin
                        irq_stat_q <= irq_stat_q & ~wb_dat_i[`I2CS_IRQ_W-1:0];
                    end
                    `I2CS_OFS_IRQ_MASK: irq_mask_q <= wb_dat_i[`I2CS_IRQ_W-1:0];
                    default: ;
                endcase
            end

            // reading the buffer empties it
            if (rd_stb && wb_adr_i == `I2CS_OFS_BUF) begin
                buffer_full_q <= 1'b0;
            end

            // byte engine
            case (state_q)
                ST_IDLE: ;
                ST_ADDR: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[6:0], sda_s};
                        bit_seen_q <= 1'b1;
                    end
                    // the fall that closes the start carries no bit
                    if (scl_fall && bit_seen_q) begin
                        bit_seen_q <= 1'b0;
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                        if (bit_cnt_q == `I2CS_LAST_BIT) begin
                            if (addr_match) begin
                                state_q <= ST_AACK;
                                rw_q <= shift_q[0];
                                data_not_addr_q <= 1'b0;
                                shift_buffer_q <= shift_q;
                                buffer_full_q <= 1'b1;
                                ack_time_flag_q <= 1'b1;
                                hold_q <= addr_hold_enable_q;
                                // without hold the address is acked at once
                                if (addr_hold_enable_q) begin
                                    clock_release_q <= 1'b0;
                                    irq_stat_q[`I2CS_IRQ_PORT] <= 1'b1;
                                end
                            end else begin
                                state_q <= ST_WAIT;
                            end
                        end
                    end
                end
                ST_AACK: begin
                    // ninth falling edge closes the address ack
                    if (scl_fall) begin
                        ack_time_flag_q <= 1'b0;
                        bit_cnt_q <= 3'h0;
                        tx_shift_q <= 8'hff;
                        if (hold_q && ack_value_select_q) begin
                            state_q <= ST_WAIT;
                        end else if (rw_q) begin
                            state_q <= ST_TX;
                            clock_release_q <= 1'b0;
                            irq_stat_q[`I2CS_IRQ_PORT] <= 1'b1;
                        end else begin
                            // this path only transmits; writes are left alone
                            state_q <= ST_WAIT;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        tx_shift_q <= {tx_shift_q[6:0], 1'b1};
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                        if (bit_cnt_q == `I2CS_LAST_BIT) begin
                            state_q <= ST_DACK;
                            buffer_full_q <= 1'b0;
                            data_not_addr_q <= 1'b1;
                        end
                    end
                end
                ST_DACK: begin
                    if (scl_rise) begin
                        ack_received_q <= sda_s;
                        ack_time_flag_q <= 1'b1;
                    end
                    if (scl_fall) begin
                        ack_time_flag_q <= 1'b0;
                        bit_cnt_q <= 3'h0;
                        tx_shift_q <= 8'hff;
                        if (!ack_received_q) begin
                            state_q <= ST_TX;
                            clock_release_q <= 1'b0;
                            irq_stat_q[`I2CS_IRQ_PORT] <= 1'b1;
                        end else begin
                            // not-ack: let go of both lines for the stop
                            state_q <= ST_WAIT;
                            clock_release_q <= 1'b1;
                            irq_stat_q[`I2CS_IRQ_NACK] <= 1'b1;
                        end
                    end
                end
                ST_WAIT: ;
                default: state_q <= ST_IDLE;
            endcase

            // start and repeated start restart the address phase
            if (start_det) begin
                state_q <= ST_ADDR;
                bit_cnt_q <= 3'h0;
                bit_seen_q <= 1'b0;
                start_seen_q <= 1'b1;
                stop_seen_q <= 1'b0;
                clock_release_q <= 1'b1;
                ack_time_flag_q <= 1'b0;
                if (start_ie_q) begin
                    irq_stat_q[`I2CS_IRQ_PORT] <= 1'b1;
                end
            end else if (stop_det) begin
                state_q <= ST_IDLE;
                start_seen_q <= 1'b0;
                stop_seen_q <= 1'b1;
                clock_release_q <= 1'b1;
                ack_time_flag_q <= 1'b0;
                irq_stat_q[`I2CS_IRQ_STOP] <= 1'b1;
            end

            // clock held low only in stretch-capable phases
            scl_oe_q <= ~clock_release_q & (state_q == ST_AACK || state_q == ST_TX);
            // ack value from software under hold, else automatic ack
            sda_oe_q <= (state_q == ST_AACK && !(hold_q && ack_value_select_q))
                | (state_q == ST_TX && !tx_shift_q[7]);
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign scl_o = line_o_q;
    assign scl_oe_o = scl_oe_q;
    assign sda_o = line_o_q;
    assign sda_oe_o = sda_oe_q;
    assign irq_o = irq_q;

endmodule // i2cs_top

`default_nettype wire

// ---- verification/i2cs_props.sv ----
`include "i2cs_map.vh"
`default_nettype none
// port checks on the slave, system clock domain only
module i2cs_props (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // bus lines and interrupt
    input wire logic scl_i,
    input wire logic scl_o,
    input wire logic scl_oe_o,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic irq_o
);
    timeunit 1ns;
    timeprecision 10ps;
    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);
    // a register write acknowledged at this edge; it took effect at the previous edge
    wire logic wr = wb_ack_o && wb_we_i && wb_sel_i[0];
    property p_ack_one; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack late");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_hi_zero; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("upper bits set");
    property p_unmapped; wb_ack_o && wb_adr_i > 8'h14 |-> wb_dat_o == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");
    property p_mask_off;
        wr && wb_adr_i == `I2CS_OFS_IRQ_MASK && wb_dat_i[2:0] == 3'h0 |-> ##2 !irq_o;
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("masked irq seen");
    property p_release;
        wr && wb_adr_i == `I2CS_OFS_CTRL && wb_dat_i[3] |-> ##[1:3] !scl_oe_o;
    endproperty
    a_release: assert property (p_release) else $error("clock still held");
    // a stretch may only begin after the clock line fell
    property p_hold_late; $rose(scl_oe_o) |-> !$past(scl_i, 2); endproperty
    a_hold_late: assert property (p_hold_late) else $error("early stretch");
    // data only moves while the clock is low
    property p_sda_low; $changed(sda_oe_o) |-> !scl_i && !$past(scl_i); endproperty
    a_sda_low: assert property (p_sda_low) else $error("data moved high");
    c_irq: cover property ($rose(irq_o));
    c_hold: cover property ($rose(scl_oe_o));
    c_ack: cover property ($rose(sda_oe_o));
endmodule // i2cs_props
bind i2cs_top i2cs_props i2cs_props_inst (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .irq_o(irq_o));
`default_nettype wire

// ---- verification/i2cs_master_mdl.sv ----
`default_nettype none
// behavioural bus master; a high output pulls its line low
module i2cs_master_mdl (
    // line levels, pulled up
    input wire logic scl_i,
    input wire logic sda_i,
    // pull-down enables
    output logic scl_dn_o,
    output logic sda_dn_o,
    // slave held the clock too long
    output logic stuck_o
);
    timeunit 1ns;
    timeprecision 10ps;
    // idle bus: both lines released
    initial begin
        scl_dn_o = 1'b0;
        sda_dn_o = 1'b0;
        stuck_o = 1'b0;
    end
    // one 125 ns slot; data set while the clock is low
    task automatic slot(input logic b, output logic r);
        int n = 0;
        sda_dn_o = !b;
        #31.25 scl_dn_o = 1'b0;
        // stretched clock stays low; bounded so a stuck slave shows up
        while (!scl_i && n < 2000) begin
            #10 n++;
        end
        stuck_o = stuck_o | !scl_i;
        #31.25 r = sda_i;
        #31.25 scl_dn_o = 1'b1;
        #31.25;
    endtask
    // data falls while the clock is high
    task automatic start();
        sda_dn_o = 1'b1;
        #62.5 scl_dn_o = 1'b1;
        #31.25;
    endtask
    // data rises while the clock is high
    task automatic stop();
        sda_dn_o = 1'b1;
        #31.25 scl_dn_o = 1'b0;
        #62.5 sda_dn_o = 1'b0;
        #125;
    endtask
    // eight bits msb first, the ninth slot carries the acknowledge
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic r);
        for (int i = 7; i >= 0; i--) slot(d[i], q[i]);
        slot(a, r);
    endtask
endmodule // i2cs_master_mdl
`default_nettype wire

// ---- verification/i2cs_top_test.sv ----
`include "i2cs_map.vh"
`default_nettype none
module i2cs_top_test;
    timeunit 1ns;
    timeprecision 10ps;
    localparam logic [7:0] r_ctl = `I2CS_OFS_CTRL, r_st = `I2CS_OFS_STATUS;
    localparam logic [7:0] r_buf = `I2CS_OFS_BUF, r_is = `I2CS_OFS_IRQ_STAT;
    logic ref_clk_i = 1'b0, resetn_i = 1'b0; // reset held low at start
    logic cyc = 1'b0, we = 1'b0; // cycle and strobe rise together
    logic [7:0] adr = 8'h00, q; // address, last byte the master read
    logic [31:0] wdat = 32'h0, dat_o, rd; // write data, read data, last read
    logic ack, scl_o, scl_oe, sda_o, sda_oe, irq; // design outputs
    logic m_scl, m_sda, stuck, ar; // master pull-downs, last ack bit
    int miscompares = 0, checked = 0;
    // open-drain lines with pull-ups
    wire logic scl = !(m_scl || (scl_oe && !scl_o));
    wire logic sda = !(m_sda || (sda_oe && !sda_o));
    always #5 ref_clk_i = !ref_clk_i;
    i2cs_top i2cs_top_inst (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe),
        .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe), .irq_o(irq));
    i2cs_master_mdl i2cs_master_mdl_inst (.scl_i(scl), .sda_i(sda), .scl_dn_o(m_scl),
        .sda_dn_o(m_sda), .stuck_o(stuck));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        if (miscompares == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // one classic cycle; the wait for ack is bounded
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge ref_clk_i);
        rd = dat_o;
        cyc <= 1'b0;
        chk({31'h0, ack}, 32'h1);
        if (ack !== 1'b1) give_verdict();
    endtask
    task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask
    task automatic wait_irq();
        for (int n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge ref_clk_i);
        chk({31'h0, irq}, 32'h1);
        if (irq !== 1'b1) give_verdict();
    endtask
    // clearing must drop the level output one cycle later
    task automatic clr_irq();
        bus(1'b1, r_is, 32'h01);
        repeat (2) @(posedge ref_clk_i);
        chk({31'h0, irq}, 32'h0);
    endtask
    task automatic load(input logic [7:0] d);
        clr_irq();
        bus(1'b1, r_buf, {24'h0, d});
        rdm(r_st, 32'h08, 32'h08);
        bus(1'b1, r_ctl, 32'h0b);
    endtask
    task automatic t_regs();
        rdm(r_ctl, 32'hff, 32'h08);
        rdm(`I2CS_OFS_OWN, 32'hff, 32'h2a);
        bus(1'b1, 8'h40, 32'hff);
        rdm(8'h40, 32'hffffffff, 32'h0);
        bus(1'b1, `I2CS_OFS_IRQ_MASK, 32'h0);
        bus(1'b1, `I2CS_OFS_IRQ_MASK, 32'h1);
    endtask
    // start interrupt off, then another slave's address
    task automatic t_foreign();
        bus(1'b1, r_ctl, 32'h09);
        i2cs_master_mdl_inst.start();
        rdm(r_st, 32'h01, 32'h01);
        rdm(r_is, 32'h01, 32'h00);
        i2cs_master_mdl_inst.xfer(8'h23, 1'b1, q, ar);
        chk({31'h0, ar}, 32'h1);
        rdm(r_is, 32'h01, 32'h00);
        i2cs_master_mdl_inst.stop();
    endtask
    task automatic t_addr();
        bus(1'b1, r_ctl, 32'h0b);
        i2cs_master_mdl_inst.start();
        wait_irq();
        clr_irq();
        fork
            i2cs_master_mdl_inst.xfer(8'h55, 1'b1, q, ar);
            begin
                wait_irq();
                rdm(r_ctl, 32'h08, 32'h00);
                rdm(r_st, 32'h1e, 32'h1a);
                chk({31'h0, scl_oe}, 32'h1);
                clr_irq();
                bus(1'b1, r_buf, 32'h77);
                rdm(r_buf, 32'hff, 32'h55);
                rdm(r_st, 32'h08, 32'h00);
                bus(1'b1, r_ctl, 32'h0b);
                wait_irq();
                rdm(r_ctl, 32'h08, 32'h00);
                load(8'ha5);
            end
        join
        chk({31'h0, ar}, 32'h0);
    endtask
    // two bytes out, the second refused by the master
    task automatic t_data();
        fork
            i2cs_master_mdl_inst.xfer(8'hff, 1'b0, q, ar);
            begin
                wait_irq();
                rdm(r_st, 32'h2c, 32'h04);
                load(8'h3c);
            end
        join
        chk({24'h0, q}, 32'ha5);
        i2cs_master_mdl_inst.xfer(8'hff, 1'b1, q, ar);
        chk({24'h0, q}, 32'h3c);
        repeat (8) @(posedge ref_clk_i);
        chk({30'h0, scl_oe, sda_oe}, 32'h0);
        rdm(r_st, 32'h20, 32'h20);
        rdm(r_is, 32'h02, 32'h02);
        chk({30'h0, scl_o, sda_o}, 32'h0);
        // unmask the not-ack event: the level must rise, then fall when masked
        bus(1'b1, `I2CS_OFS_IRQ_MASK, 32'h2);
        repeat (2) @(posedge ref_clk_i);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, `I2CS_OFS_IRQ_MASK, 32'h0);
        repeat (2) @(posedge ref_clk_i);
        chk({31'h0, irq}, 32'h0);
        i2cs_master_mdl_inst.stop();
        chk({31'h0, stuck}, 32'h0);
        rdm(r_st, 32'h41, 32'h40);
        rdm(r_is, 32'h04, 32'h04);
    endtask
    // reset, then the scenarios in order
    initial begin
        repeat (4) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        t_regs();
        t_foreign();
        t_addr();
        t_data();
        give_verdict();
    end
endmodule // i2cs_top_test
`default_nettype wire
